// file: core/timer_watchdog_pkg.sv
// Constants, field layouts and types shared by the timer and watchdog block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package timer_watchdog_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] OFS_TIMER_COUNT   = 8'h00;
    localparam logic [7:0] OFS_TIMER_CTRL    = 8'h04;
    localparam logic [7:0] OFS_WDOG_CTRL     = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h14;
    localparam logic [7:0] OFS_PRESCALE_VIEW = 8'h18;

    // Bus widths and answers
    localparam int         ADDR_W      = 8;
    localparam int         DATA_W      = 32;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timer control field: source, edge, prescaler assign, ratio select
    typedef struct packed {
        logic       src_sel;
        logic       edge_sel;
        logic       pre_en;
        logic [2:0] pre_sel;
    } timer_ctrl_t;
    localparam int          TIMER_CTRL_W   = 6;
    localparam timer_ctrl_t TIMER_CTRL_RST = 6'h3f;

    // Watchdog control field: enable and ratio select
    typedef struct packed {
        logic       enable;
        logic [2:0] pre_sel;
    } wdog_ctrl_t;
    localparam int         WDOG_CTRL_W   = 4;
    localparam wdog_ctrl_t WDOG_CTRL_RST = 4'h0;

    // Interrupt bits, same layout in status, clear and enable
    typedef struct packed {
        logic wdog_timeout;
        logic timer_overflow;
    } irq_bits_t;
    localparam int        IRQ_W   = 2;
    localparam irq_bits_t IRQ_RST = 2'h0;

    // Counter geometry and reset values
    localparam int         CNT_W       = 8;
    localparam logic [7:0] CNT_RST     = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hff;
    localparam logic [3:0] TIMER_SEL_OFS = 4'h1;

    // Operating modes of the device, one-hot
    typedef enum logic [3:0] {
        MODE_NORMAL = 4'b0001,
        MODE_GREEN  = 4'b0010,
        MODE_IDLE   = 4'b0100,
        MODE_SLEEP  = 4'b1000
    } op_mode_t;

endpackage

// file: core/timer_watchdog_prescaler.sv
// Main 8-bit timer/counter and watchdog, each with an 8-bit prescaler, behind AXI4-Lite.
// Assumes i_clk is the instruction clock; timer pin and sub-oscillator arrive asynchronously.
// Operation
// - Two separate 8-bit prescaler counters, one for timer, one for watchdog.
// - Timer ratio from timer control select; watchdog ratio from watchdog control select.
// - Any write to the timer count clears the timer prescaler; here only a write with byte lane 0 strobed does.
// - Watchdog clear or sleep instruction clears the watchdog prescaler.
// - Timer count is an 8-bit software readable and writable counter.
// - Timer source selectable internal or pin; pin edge selectable.
// - Internal source without prescaling counts one per instruction cycle.
// - Pin source counts one per selected pin edge.
// - Watchdog runs from sub-oscillator, also with main oscillator off.
// - Enabled watchdog time-out in normal, green or idle resets the device.
// - Watchdog enable bit writable in normal or green mode only.
// - Time-out period is prescale times 256 over half sub-oscillator rate.
// - Source select 0 counts instruction clock, 1 counts pin; pin slower than clock.
// - Edge select 0 counts rising pin edges, 1 falling edges.
// - Assign bit 0 gives 1:1; else select gives 1:2 to 1:256.
// - Watchdog select gives 1:1 to 1:128 on the sub-oscillator clock.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
module timer_watchdog_prescaler
    import timer_watchdog_pkg::*;
(
    input  wire logic                          i_clk,
    input  wire logic                          i_reset_n,
    input  wire logic                          i_clk_en,
    input  wire logic                          i_main_osc_on,
    input  wire timer_watchdog_pkg::op_mode_t  i_mode,
    input  wire logic                          i_watchdog_clear_instr,
    input  wire logic                          i_sleep_instr,
    input  wire logic                          i_timer_pin,
    input  wire logic                          i_sub_osc_clock,
    input  wire logic [timer_watchdog_pkg::ADDR_W-1:0] i_axi_awaddr,
    input  wire logic                          i_axi_awvalid,
    output logic                               o_axi_awready,
    input  wire logic [timer_watchdog_pkg::DATA_W-1:0] i_axi_wdata,
    input  wire logic [3:0]                    i_axi_wstrb,
    input  wire logic                          i_axi_wvalid,
    output logic                               o_axi_wready,
    output logic [1:0]                         o_axi_bresp,
    output logic                               o_axi_bvalid,
    input  wire logic                          i_axi_bready,
    input  wire logic [timer_watchdog_pkg::ADDR_W-1:0] i_axi_araddr,
    input  wire logic                          i_axi_arvalid,
    output logic                               o_axi_arready,
    output logic [timer_watchdog_pkg::DATA_W-1:0] o_axi_rdata,
    output logic [1:0]                         o_axi_rresp,
    output logic                               o_axi_rvalid,
    input  wire logic                          i_axi_rready,
    output logic                               o_timer_overflow,
    output logic                               o_watchdog_reset,
    output logic                               o_irq
);
    import timer_watchdog_pkg::*;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Mask of n low ones; a prescaler tick fires when its masked bits are all set
    function automatic logic [7:0] ratio_mask(input logic [3:0] n);
        logic [8:0] t;
        t = 9'h001 << n;
        return 8'(t - 9'h001);
    endfunction

    logic                  aw_held_q;
    logic [ADDR_W-1:0]     awaddr_q;
    logic                  w_held_q;
    logic [DATA_W-1:0]     wdata_q;
    logic                  wlane0_q;
    logic                  do_write;
    logic                  wr_count;
    logic                  wr_lane;
    logic                  wr_known;
    logic                  rd_known;
    logic [DATA_W-1:0]     rd_data;
    timer_ctrl_t           tctrl_q;
    wdog_ctrl_t            wctrl_q;
    irq_bits_t             status_q;
    irq_bits_t             status_d;
    irq_bits_t             ien_q;
    irq_bits_t             clr_bits;
    irq_bits_t             events;
    logic [CNT_W-1:0]      count_q;
    logic [CNT_W-1:0]      tmr_pre_q;
    logic [CNT_W-1:0]      wdp_q;
    logic [CNT_W-1:0]      wdc_q;
    logic                  pin_s1_q, pin_s2_q, pin_s3_q;
    logic                  sub_s1_q, sub_s2_q, sub_s3_q;
    logic                  half_q;
    logic                  tmr_tick;
    logic                  tmr_inc;
    logic                  base_tick;
    logic                  wd_tick;
    logic                  wd_clear;
    logic                  wd_expire;
    logic                  mode_can_reset;
    logic                  mode_can_enable;
    logic [7:0]            tmask;
    logic [7:0]            wmask;

    // Write channel: address and data taken in either order, answered once both are in
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wlane0_q      <= 1'b0;
            o_axi_awready <= 1'b0;
            o_axi_wready  <= 1'b0;
            o_axi_bvalid  <= 1'b0;
            o_axi_bresp   <= RESP_OKAY;
        end else if (i_clk_en) begin
            if (o_axi_bvalid && i_axi_bready) begin
                o_axi_bvalid  <= 1'b0;
                aw_held_q     <= 1'b0;
                w_held_q      <= 1'b0;
                o_axi_awready <= 1'b1;
                o_axi_wready  <= 1'b1;
            end else begin
                if (!aw_held_q && !o_axi_awready) begin
                    o_axi_awready <= 1'b1;
                end
                if (!w_held_q && !o_axi_wready) begin
                    o_axi_wready <= 1'b1;
                end
                if (i_axi_awvalid && o_axi_awready) begin
                    aw_held_q     <= 1'b1;
                    awaddr_q      <= i_axi_awaddr;
                    o_axi_awready <= 1'b0;
                end
                if (i_axi_wvalid && o_axi_wready) begin
                    w_held_q     <= 1'b1;
                    wdata_q      <= i_axi_wdata;
                    wlane0_q     <= i_axi_wstrb[0];
                    o_axi_wready <= 1'b0;
                end
                if (do_write) begin
                    o_axi_bvalid <= 1'b1;
                    o_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
                end
            end
        end
    end

    // Write decode; writable registers are 8 bits or less, so only byte lane 0 matters
    assign do_write = aw_held_q && w_held_q && !o_axi_bvalid;
    assign wr_lane  = do_write && wlane0_q;
    assign wr_count = wr_lane && (awaddr_q == OFS_TIMER_COUNT);
    assign wr_known = (awaddr_q == OFS_TIMER_COUNT) || (awaddr_q == OFS_TIMER_CTRL)
                   || (awaddr_q == OFS_WDOG_CTRL) || (awaddr_q == OFS_IRQ_STATUS)
                   || (awaddr_q == OFS_IRQ_CLEAR) || (awaddr_q == OFS_IRQ_ENABLE)
                   || (awaddr_q == OFS_PRESCALE_VIEW);

    // Read mux; unmapped addresses answer zero with an error
    always_comb begin
        rd_data  = '0;
        rd_known = 1'b1;
        case (i_axi_araddr)
            OFS_TIMER_COUNT:   rd_data[CNT_W-1:0]        = count_q;
            OFS_TIMER_CTRL:    rd_data[TIMER_CTRL_W-1:0] = tctrl_q;
            OFS_WDOG_CTRL:     rd_data[WDOG_CTRL_W-1:0]  = wctrl_q;
            OFS_IRQ_STATUS:    rd_data[IRQ_W-1:0]        = status_q;
            OFS_IRQ_CLEAR:     rd_data                   = '0;
            OFS_IRQ_ENABLE:    rd_data[IRQ_W-1:0]        = ien_q;
            OFS_PRESCALE_VIEW: rd_data[15:0]             = {wdp_q, tmr_pre_q};
            default:           rd_known                  = 1'b0;
        endcase
    end

    // Read channel: one read at a time, data one cycle after the address
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= '0;
            o_axi_rresp   <= RESP_OKAY;
        end else if (i_clk_en) begin
            if (o_axi_rvalid && i_axi_rready) begin
                o_axi_rvalid  <= 1'b0;
                o_axi_arready <= 1'b1;
            end else if (i_axi_arvalid && o_axi_arready) begin
                o_axi_arready <= 1'b0;
                o_axi_rvalid  <= 1'b1;
                o_axi_rdata   <= rd_data;
                o_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (!o_axi_rvalid) begin
                o_axi_arready <= 1'b1;
            end
        end
    end

    // What each operating mode allows the watchdog to do
    always_comb begin
        mode_can_reset  = 1'b0;
        mode_can_enable = 1'b0;
        case (i_mode)
            MODE_NORMAL, MODE_GREEN: begin
                mode_can_reset  = 1'b1;
                mode_can_enable = 1'b1;
            end
            MODE_IDLE: mode_can_reset = 1'b1;
            default:   mode_can_reset = 1'b0; // Sleep and unknown codes never reset
        endcase
    end

    // Control registers; reset value leaves the timer on the pin, falling edge, 1:256
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tctrl_q <= TIMER_CTRL_RST;
            wctrl_q <= WDOG_CTRL_RST;
            ien_q   <= IRQ_RST;
        end else if (i_clk_en && wr_lane) begin
            if (awaddr_q == OFS_TIMER_CTRL) begin
                tctrl_q <= wdata_q[TIMER_CTRL_W-1:0];
            end
            if (awaddr_q == OFS_WDOG_CTRL) begin
                wctrl_q.pre_sel <= wdata_q[2:0];
                if (mode_can_enable) begin
                    wctrl_q.enable <= wdata_q[3];
                end
            end
            if (awaddr_q == OFS_IRQ_ENABLE) begin
                ien_q <= wdata_q[IRQ_W-1:0];
            end
        end
    end

    // Three-flop synchronisers; only the second stage and later are looked at
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end else if (i_clk_en) begin
            pin_s1_q <= i_timer_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            sub_s1_q <= i_sub_osc_clock;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end

    // Timer tick source; the pin must toggle slower than the instruction clock
    always_comb begin
        if (tctrl_q.src_sel) begin
            tmr_tick = tctrl_q.edge_sel ? (pin_s3_q && !pin_s2_q) : (pin_s2_q && !pin_s3_q);
        end else begin
            tmr_tick = i_main_osc_on;
        end
    end

    // Prescaler assign off bypasses the divider entirely
    assign tmask   = ratio_mask(4'(tctrl_q.pre_sel) + TIMER_SEL_OFS);
    assign tmr_inc = tmr_tick && (!tctrl_q.pre_en || ((tmr_pre_q & tmask) == tmask));

    // Timer prescaler and count; a software write wins over a tick in the same cycle
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tmr_pre_q        <= CNT_RST;
            count_q          <= CNT_RST;
            o_timer_overflow <= 1'b0;
        end else if (i_clk_en) begin
            o_timer_overflow <= 1'b0;
            if (wr_count) begin
                tmr_pre_q <= CNT_RST;
                count_q   <= wdata_q[CNT_W-1:0];
            end else begin
                if (tmr_tick && tctrl_q.pre_en) begin
                    tmr_pre_q <= tmr_pre_q + 8'h01;
                end
                if (tmr_inc) begin
                    count_q          <= count_q + 8'h01;
                    o_timer_overflow <= (count_q == CNT_MAX);
                end
            end
        end
    end

    // Watchdog base tick at half the sub-oscillator rate, then the selected ratio
    assign base_tick = sub_s2_q && !sub_s3_q && half_q;
    assign wmask     = ratio_mask({1'b0, wctrl_q.pre_sel});
    assign wd_tick   = base_tick && ((wdp_q & wmask) == wmask);
    assign wd_clear  = i_watchdog_clear_instr || i_sleep_instr;
    assign wd_expire = wctrl_q.enable && !wd_clear && wd_tick && (wdc_q == CNT_MAX);

    // Watchdog counts regardless of the main oscillator; disabled means held at zero
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            half_q           <= 1'b0;
            wdp_q            <= CNT_RST;
            wdc_q            <= CNT_RST;
            o_watchdog_reset <= 1'b0;
        end else if (i_clk_en) begin
            if (sub_s2_q && !sub_s3_q) begin
                half_q <= !half_q;
            end
            if (wd_clear || !wctrl_q.enable) begin
                wdp_q <= CNT_RST;
                wdc_q <= CNT_RST;
            end else if (base_tick) begin
                wdp_q <= wdp_q + 8'h01;
                if (wd_tick) begin
                    wdc_q <= wdc_q + 8'h01;
                end
            end
            o_watchdog_reset <= wd_expire && mode_can_reset;
        end
    end

    // Sticky status: a new event beats a clear in the same cycle
    assign events.timer_overflow = tmr_inc && (count_q == CNT_MAX) && !wr_count;
    assign events.wdog_timeout   = wd_expire;
    assign clr_bits = (wr_lane && (awaddr_q == OFS_IRQ_CLEAR)) ? irq_bits_t'(wdata_q[IRQ_W-1:0]) : IRQ_RST;
    assign status_d = (status_q & ~clr_bits) | events;

    // Interrupt level follows the enabled status one cycle later
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            status_q <= IRQ_RST;
            o_irq    <= 1'b0;
        end else if (i_clk_en) begin
            status_q <= status_d;
            o_irq    <= |(status_q & ien_q);
        end
    end

    // Assertions
    sequence count_write_s;
        i_clk_en && wr_count;
    endsequence

    sequence wdog_expiry_s;
        i_clk_en && wd_expire;
    endsequence

    timer_pre_clear_a: assert property (count_write_s |=> tmr_pre_q == CNT_RST)
        else $error("timer prescaler not cleared by count write");
    count_write_a: assert property (count_write_s |=> count_q == $past(wdata_q[CNT_W-1:0]))
        else $error("timer count write not stored");
    wdog_pre_clear_a: assert property (i_clk_en && wd_clear |=> wdp_q == CNT_RST && wdc_q == CNT_RST)
        else $error("watchdog prescaler not cleared");
    timer_internal_a: assert property (i_clk_en && !tctrl_q.src_sel && !tctrl_q.pre_en && i_main_osc_on
                                       && !wr_count |=> count_q == $past(count_q) + 8'h01)
        else $error("internal source did not count one per cycle");
    timer_pin_hold_a: assert property (i_clk_en && tctrl_q.src_sel && (pin_s2_q == pin_s3_q) && !wr_count
                                       |=> count_q == $past(count_q))
        else $error("timer moved without a pin edge");
    overflow_wrap_a: assert property (o_timer_overflow |-> count_q == CNT_RST)
        else $error("overflow flagged without wrap to zero");
    wdog_reset_a: assert property (wdog_expiry_s ##0 mode_can_reset |=> o_watchdog_reset
                                   ##1 (!o_watchdog_reset || !$past(i_clk_en)))
        else $error("watchdog expiry did not reset device");
    wdog_sleep_a: assert property (i_clk_en && i_mode == MODE_SLEEP |=> !o_watchdog_reset)
        else $error("watchdog reset issued in sleep");
    wdog_enable_lock_a: assert property (!mode_can_enable |=> wctrl_q.enable == $past(wctrl_q.enable))
        else $error("watchdog enable changed outside normal or green");
    irq_level_a: assert property (i_clk_en |=> o_irq == |($past(status_q) & $past(ien_q)))
        else $error("interrupt level does not follow status and enable");
    bresp_hold_a: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid && $stable(o_axi_bresp))
        else $error("write response dropped before taken");

endmodule

// file: dv/timer_pin_source.sv
// Far-side model: external timer pin driver and a free-running sub-oscillator.
// Assumes one bench thread calls toggle() at a time, just after a clock edge.
module timer_pin_source (
    input  wire logic i_clk,
    output logic      o_pin,
    output logic      o_sub_osc
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin idles low, oscillator starts low
    initial o_pin = 1'b0;
    initial o_sub_osc = 1'b0;

    // Oscillator runs free, phase unrelated to i_clk, each level above two cycles
    always #230 o_sub_osc = ~o_sub_osc;

    // Four cycles a level keeps the pin period above the clock period
    task automatic toggle(input int n);
        repeat (n) begin
            repeat (4) @(posedge i_clk);
            o_pin <= ~o_pin;
        end
    endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the timer and watchdog block over AXI4-Lite.
// Assumes the package constants and a 100 ns clock; pin and oscillator come from the partner.
module testbench
    import timer_watchdog_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0, rst_n = 1'b0, osc_on = 1'b0, wcl = 1'b0, slp = 1'b0;
    op_mode_t    mode = MODE_NORMAL;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic        pin, sub_osc, ovf, wdr, irq, awr, wr, bv, arr, rv;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          num_errors = 0, num_checks = 0, ovf_n = 0, wdr_n = 0;

    always #50 clk = ~clk;

    timer_pin_source p (.i_clk(clk), .o_pin(pin), .o_sub_osc(sub_osc));

    timer_watchdog_prescaler uut (
        .i_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .i_main_osc_on(osc_on), .i_mode(mode),
        .i_watchdog_clear_instr(wcl), .i_sleep_instr(slp), .i_timer_pin(pin), .i_sub_osc_clock(sub_osc),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_wdata(wdata),
        .i_axi_wstrb(4'hf), .i_axi_wvalid(wv), .o_axi_wready(wr), .o_axi_bresp(bresp), .o_axi_bvalid(bv),
        .i_axi_bready(bre), .i_axi_araddr(araddr), .i_axi_arvalid(arv), .o_axi_arready(arr),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rv), .i_axi_rready(rre),
        .o_timer_overflow(ovf), .o_watchdog_reset(wdr), .o_irq(irq)
    );

    // One-cycle pulses are counted at every edge so none slips by
    always @(posedge clk) begin
        if (ovf === 1'b1) ovf_n++;
        if (wdr === 1'b1) wdr_n++;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A wait that ran out ends the run
    task automatic limit(input int n, input int bound = 60);
        if (n >= bound) begin
            num_errors++;
            $display("ERROR wait expected within %0d cycles seen none", bound);
            tally_and_finish();
        end
    endtask

    // Address and data offered together, each dropped at its own take
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 60);
        limit(n);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        bre <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string name);
        int n;
        n = 0;
        araddr <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arr === 1'b1) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 60);
        limit(n);
        chk(name, rdata, exp);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rre <= 1'b0;
        @(posedge clk);
    endtask

    // Exactly k edges see the main oscillator running, then it settles
    task automatic run_osc(input int k);
        osc_on <= 1'b1;
        repeat (k) @(posedge clk);
        osc_on <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse(input bit sl);
        if (sl) slp <= 1'b1;
        else wcl <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        wcl <= 1'b0;
        @(posedge clk);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axr(OFS_TIMER_CTRL, 32'h3f, RESP_OKAY, "timer ctrl");
        axr(OFS_WDOG_CTRL, 32'h0, RESP_OKAY, "wdog ctrl");
        axr(OFS_TIMER_COUNT, 32'h0, RESP_OKAY, "count");
        axr(8'h40, 32'h0, RESP_SLVERR, "unmapped");
        axw(8'h40, 32'h0, RESP_SLVERR);
        $display("test reset done");
        axw(OFS_TIMER_CTRL, 32'h00, RESP_OKAY);
        axw(OFS_TIMER_COUNT, 32'h10, RESP_OKAY);
        run_osc(37);
        axr(OFS_TIMER_COUNT, 32'h35, RESP_OKAY, "count 1:1");
        // Each code runs two and a half periods, so an off-by-one ratio shows
        for (int s = 0; s < 8; s++) begin
            axw(OFS_TIMER_CTRL, 32'h08 | s, RESP_OKAY);
            axw(OFS_TIMER_COUNT, 32'h0, RESP_OKAY);
            run_osc(5 << s);
            axr(OFS_TIMER_COUNT, 32'h2, RESP_OKAY, "count prescaled");
        end
        axr(OFS_PRESCALE_VIEW, 32'h80, RESP_OKAY, "timer prescaler");
        axw(OFS_TIMER_COUNT, 32'h33, RESP_OKAY);
        axr(OFS_PRESCALE_VIEW, 32'h0, RESP_OKAY, "prescaler cleared");
        axr(OFS_TIMER_COUNT, 32'h33, RESP_OKAY, "count written");
        $display("test timer internal done");
        // Wrap raises the interrupt when enabled, then masked
        axw(OFS_TIMER_CTRL, 32'h00, RESP_OKAY);
        for (int m = 1; m >= 0; m--) begin
            axw(OFS_IRQ_ENABLE, m, RESP_OKAY);
            axw(OFS_TIMER_COUNT, 32'hfe, RESP_OKAY);
            run_osc(2);
            axr(OFS_TIMER_COUNT, 32'h0, RESP_OKAY, "wrapped");
            axr(OFS_IRQ_STATUS, 32'h1, RESP_OKAY, "overflow status");
            chk("irq", {31'h0, irq}, m);
            axw(OFS_IRQ_CLEAR, 32'h1, RESP_OKAY);
            axr(OFS_IRQ_STATUS, 32'h0, RESP_OKAY, "status cleared");
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        chk("overflow pulses", ovf_n, 32'h2);
        $display("test overflow done");
        // Pin from low: four toggles give two rises, then three give one fall
        axw(OFS_TIMER_CTRL, 32'h20, RESP_OKAY);
        axw(OFS_TIMER_COUNT, 32'h0, RESP_OKAY);
        p.toggle(4);
        repeat (6) @(posedge clk);
        axr(OFS_TIMER_COUNT, 32'h2, RESP_OKAY, "rising edges");
        axw(OFS_TIMER_CTRL, 32'h30, RESP_OKAY);
        p.toggle(3);
        repeat (6) @(posedge clk);
        axr(OFS_TIMER_COUNT, 32'h3, RESP_OKAY, "falling edges");
        $display("test timer pin done");
        mode <= MODE_SLEEP;
        axw(OFS_WDOG_CTRL, 32'h9, RESP_OKAY);
        axr(OFS_WDOG_CTRL, 32'h1, RESP_OKAY, "enable refused");
        mode <= MODE_GREEN;
        axw(OFS_WDOG_CTRL, 32'h8, RESP_OKAY);
        axr(OFS_WDOG_CTRL, 32'h8, RESP_OKAY, "enable taken");
        // Clears and sleeps well inside the period keep it from expiring
        for (int i = 0; i < 4; i++) begin
            pulse(i[0]);
            repeat (1800) @(posedge clk);
        end
        chk("no watchdog reset", wdr_n, 32'h0);
        // Main oscillator stays off; period is 512 oscillator periods times the ratio
        for (int s = 0; s < 2; s++) begin
            int n, lo;
            axw(OFS_WDOG_CTRL, 32'h8 | s, RESP_OKAY);
            mode <= s ? MODE_GREEN : MODE_IDLE;
            pulse(1'b0);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (wdr !== 1'b1 && n < 9000);
            limit(n, 9000);
            lo = (512 << s) * 46 / 10 - 20;
            chk("timeout window", {31'h0, n >= lo && n <= lo + 35}, 32'h1);
            axr(OFS_IRQ_STATUS, 32'h2, RESP_OKAY, "wdog status");
            axw(OFS_IRQ_CLEAR, 32'h2, RESP_OKAY);
        end
        chk("watchdog resets", wdr_n, 32'h2);
        $display("test watchdog done");
        tally_and_finish();
    end
endmodule
